//--- design/mflc_defs.svh
// Constants for the mapper format and loopback control register bank.
// Assumes an 8-bit microprocessor address and data path.
`ifndef MFLC_DEFS_SVH
`define MFLC_DEFS_SVH

// Register offsets on the processor port.
`define MFLC_BUS_MAPPING_CONFIG_ADDR        8'hc0
`define MFLC_LINE_CODING_LOOPBACK_CTRL_ADDR 8'hc1

// Field positions in bus_mapping_config.
`define MFLC_FORMAT_SELECT_HIGH_BIT 7
`define MFLC_FORMAT_SELECT_LOW_BIT  6
`define MFLC_DROP_SLOT_MSB          5
`define MFLC_DROP_SLOT_LSB          4
`define MFLC_ADD_SLOT_MSB           3
`define MFLC_ADD_SLOT_LSB           2
`define MFLC_TEST_BIT               1
`define MFLC_DS3_MODE_BIT           0

// Field positions in line_coding_loopback_ctrl.
`define MFLC_TX_RAIL_ENABLE_BIT     7
`define MFLC_RX_RAIL_ENABLE_BIT     6
`define MFLC_TX_CLK_INV_BIT         5
`define MFLC_RX_CLK_INV_BIT         4
`define MFLC_RING_MODE_BIT          3
`define MFLC_FACILITY_LBK_BIT       2
`define MFLC_LINE_LBK_BIT           1
`define MFLC_SONET_LBK_BIT          0

// Field positions in the G1 byte.
`define MFLC_G1_FEBE_MSB            7
`define MFLC_G1_FEBE_LSB            4
`define MFLC_G1_RDI_BIT             3

// Reset value of non-configuration state and unmapped read data.
`define MFLC_ZERO_BYTE              8'h00

`endif

//--- design/mflc_pkg.sv
// Types shared by the mapper format and loopback control bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mflc_pkg;

	// Bus format selection, format_select_high then format_select_low.
	typedef enum logic [1:0] {
		MFLC_FMT_STS1,
		MFLC_FMT_FORMAT_SELECT_LOW,
		MFLC_FMT_RESERVED,
		MFLC_FMT_FORMAT_SELECT_HIGH
	} mflc_format_t;

	// Slot selection used for both drop and add.
	typedef enum logic [1:0] {
		MFLC_SLOT_A,
		MFLC_SLOT_B,
		MFLC_SLOT_C,
		MFLC_SLOT_IDLE
	} mflc_slot_t;

	// Decoded configuration presented to the rest of the mapper.
	typedef struct packed {
		mflc_format_t format_sel;
		logic         format_valid;
		mflc_slot_t   drop_slot_select;
		logic         rx_front_reset;
		mflc_slot_t   add_slot_select;
		logic         ds3_mode;
		logic         transmit_clock_inversion;
		logic         receive_clock_inversion;
		logic         ring_mode;
		logic         facility_loopback_enable;
		logic         line_loopback_enable;
	} mflc_cfg_t;

	// Alarm state and settings reported by the companion mapper.
	typedef struct packed {
		logic       format_select_high;
		logic       alarm_source_select;
		logic       label_alarm_enable;
		logic       pointer_loss_alarm;
		logic       path_ais_alarm;
		logic       j1_loss_alarm;
		logic       e1_byte_ais_alarm;
		logic       external_status_input;
		logic       path_ais_lead;
		logic       signal_label_mismatch;
		logic       unequipped_label_detect;
		logic [3:0] febe_count;
	} mflc_alarm_t;

	// Complete state of the bank.
	typedef struct packed {
		logic [7:0] bus_mapping_config;
		logic [7:0] line_coding_loopback_ctrl;
		logic [7:0] rdata;
		logic       transmit_line_clock_prev;
		logic       rclk_prev;
		logic       tx_data;
		logic       tx_valid;
		logic       rx_pos;
		logic       rx_neg;
		logic       ami_polarity;
		logic       rdi;
		logic [7:0] g1;
	} mflc_state_t;

endpackage : mflc_pkg

`default_nettype wire

//--- design/mflc_top.sv
// Configuration control bits of a DS3/E3 to SDH/SONET mapper: two 8-bit
// registers with their decoded format, slot, line coding, clock edge,
// ring G1 and loopback behaviour.
// Assumes every input is synchronous to CLK; line clocks are sampled.
//
// What this block does
// - Control bits get no default pattern at power-up.
// - Neither hardware nor software reset alters the control bits.
// - Bits 7:6 select STS-1, STS-3, TUG-3; value 10 is reserved.
// - Bits 5:4 pick drop slot A, B, C; 11 idles receive front end.
// - Bits 3:2 pick add slot A, B, C; 11 is undefined.
// - Bit 0 selects E3 when zero, DS3 when one.
// - Transmit rail decoding when enabled, NRZ bypass otherwise.
// - Receive rail coding when enabled, NRZ bypass otherwise.
// - Transmit data sampled on rising clock edge, falling when inverted except in line loopback.
// - Receive data launched on falling edge, rising when inverted.
// - Ring mode inserts companion FEBE count and RDI into G1.
// - External G1 source selected takes G1 from overhead port.
// - Companion RDI raised from pointer, AIS, J1, label alarm terms.
// - Facility loopback returns transmit line data and clock to receive.
// - Line loopback returns receive signal to transmit, receive still driven.
`include "mflc_defs.svh"
`default_nettype none

module mflc_top (
	// Clock and reset.
	input  wire logic                CLK,
	input  wire logic                SRST,
	// Microprocessor register port.
	input  wire logic [7:0]          UP_ADDR,
	input  wire logic [7:0]          UP_WDATA,
	input  wire logic                UP_WR,
	input  wire logic                UP_RD,
	output logic      [7:0]          UP_RDATA,
	// Transmit line interface.
	input  wire logic                TX_LINE_CLK,
	input  wire logic                TX_LINE_POS,
	input  wire logic                TX_LINE_NEG,
	// Transmit data toward the mapper core.
	output logic                     TX_CORE_DATA,
	output logic                     TX_CORE_VALID,
	// Receive data from the desynchroniser.
	input  wire logic                RX_CORE_CLK,
	input  wire logic                RX_CORE_DATA,
	// Receive line interface.
	output logic                     RX_LINE_CLK,
	output logic                     RX_LINE_POS,
	output logic                     RX_LINE_NEG,
	// G1 byte sources and result.
	input  wire logic [7:0]          G1_INTERNAL,
	input  wire logic [7:0]          G1_EXTERNAL,
	input  wire logic                G1_EXTERNAL_SEL,
	input  wire mflc_pkg::mflc_alarm_t ALARM_IN,
	output logic      [7:0]          G1_OUT,
	output logic                     RDI_OUT,
	// Decoded configuration.
	output mflc_pkg::mflc_cfg_t      CFG
);

	mflc_pkg::mflc_state_t state_reg;
	mflc_pkg::mflc_state_t state_next;

	logic [7:0] c0;
	logic [7:0] c1;
	logic       tx_nrz;
	logic       rx_src_clk;
	logic       rx_src_data;
	logic       tx_src_clk;
	logic       tx_src_data;
	logic       tx_src_inv;
	logic       rx_src_clk_prev;
	logic       transmit_line_clock_edge;
	logic       rclk_edge;
	logic       rdi_now;

	assign c0 = state_reg.bus_mapping_config;
	assign c1 = state_reg.line_coding_loopback_ctrl;

	// Rail decoding merges both rails into one NRZ stream; zero
	// substitution codes are not undone here, only the rail merge.
	assign tx_nrz = c1[`MFLC_TX_RAIL_ENABLE_BIT] ?
		(TX_LINE_POS | TX_LINE_NEG) : TX_LINE_POS;

	// Receive side source: facility loopback feeds the transmit line
	// back, otherwise the desynchroniser drives the receive line.
	assign rx_src_clk  = c1[`MFLC_FACILITY_LBK_BIT] ?
		TX_LINE_CLK : RX_CORE_CLK;
	assign rx_src_data = c1[`MFLC_FACILITY_LBK_BIT] ?
		tx_nrz : RX_CORE_DATA;

	// Transmit side source: line loopback takes the receive signal, which
	// is launched on its own edge, so it is always sampled on the rising.
	assign tx_src_clk  = c1[`MFLC_LINE_LBK_BIT] ?
		RX_CORE_CLK : TX_LINE_CLK;
	assign tx_src_data = c1[`MFLC_LINE_LBK_BIT] ?
		RX_CORE_DATA : tx_nrz;
	assign tx_src_inv  = c1[`MFLC_LINE_LBK_BIT] ?
		1'b0 : c1[`MFLC_TX_CLK_INV_BIT];

	// The previous-level flop follows whichever clock is the source.
	assign rx_src_clk_prev = state_reg.rclk_prev;

	// Sampling edge of the transmit clock.
	assign transmit_line_clock_edge = tx_src_inv ?
		(state_reg.transmit_line_clock_prev & ~tx_src_clk) :
		(~state_reg.transmit_line_clock_prev & tx_src_clk);

	// Launch edge of the receive clock.
	assign rclk_edge = c1[`MFLC_RX_CLK_INV_BIT] ?
		(~rx_src_clk_prev & rx_src_clk) :
		(rx_src_clk_prev & ~rx_src_clk);

	// Remote defect seen at the companion mapper.
	assign rdi_now =
		(ALARM_IN.format_select_high &
		 (ALARM_IN.pointer_loss_alarm | ALARM_IN.path_ais_alarm)) |
		ALARM_IN.j1_loss_alarm |
		(~ALARM_IN.alarm_source_select & ALARM_IN.e1_byte_ais_alarm) |
		(ALARM_IN.alarm_source_select &
		 (ALARM_IN.external_status_input | ALARM_IN.path_ais_lead)) |
		(ALARM_IN.label_alarm_enable &
		 (ALARM_IN.signal_label_mismatch |
		  ALARM_IN.unequipped_label_detect));

	// Next state. The two configuration bytes are loaded only by a write
	// and are left out of the reset branch on purpose, so that a reset
	// never disturbs a running configuration.
	always_comb begin
		state_next = state_reg;
		if (UP_WR) begin
			if (UP_ADDR == `MFLC_BUS_MAPPING_CONFIG_ADDR) begin
				state_next.bus_mapping_config = UP_WDATA;
			end else if (UP_ADDR == `MFLC_LINE_CODING_LOOPBACK_CTRL_ADDR) begin
				state_next.line_coding_loopback_ctrl = UP_WDATA;
			end
		end
		// Read data; unmapped addresses read as zero.
		if (UP_RD) begin
			if (UP_ADDR == `MFLC_BUS_MAPPING_CONFIG_ADDR) begin
				state_next.rdata = c0;
			end else if (UP_ADDR == `MFLC_LINE_CODING_LOOPBACK_CTRL_ADDR) begin
				state_next.rdata = c1;
			end else begin
				state_next.rdata = `MFLC_ZERO_BYTE;
			end
		end
		state_next.transmit_line_clock_prev = tx_src_clk;
		state_next.rclk_prev = rx_src_clk;
		// Transmit sample toward the core, valid for one cycle.
		state_next.tx_valid = transmit_line_clock_edge;
		if (transmit_line_clock_edge) begin
			state_next.tx_data = tx_src_data;
		end
		// Receive launch, alternating marks between rails when coding.
		if (rclk_edge) begin
			if (c1[`MFLC_RX_RAIL_ENABLE_BIT]) begin
				state_next.rx_pos = rx_src_data & ~state_reg.ami_polarity;
				state_next.rx_neg = rx_src_data & state_reg.ami_polarity;
				if (rx_src_data) begin
					state_next.ami_polarity = ~state_reg.ami_polarity;
				end
			end else begin
				state_next.rx_pos = rx_src_data;
				state_next.rx_neg = 1'b0;
			end
		end
		// G1 byte: the overhead port wins, then ring insertion.
		state_next.rdi = rdi_now;
		if (G1_EXTERNAL_SEL) begin
			state_next.g1 = G1_EXTERNAL;
		end else if (c1[`MFLC_RING_MODE_BIT]) begin
			state_next.g1 = G1_INTERNAL;
			state_next.g1[`MFLC_G1_FEBE_MSB:`MFLC_G1_FEBE_LSB] =
				ALARM_IN.febe_count;
			state_next.g1[`MFLC_G1_RDI_BIT] = rdi_now;
		end else begin
			state_next.g1 = G1_INTERNAL;
		end
		// Reset clears only datapath state, never the control bytes.
		if (SRST) begin
			state_next.rdata        = `MFLC_ZERO_BYTE;
			state_next.transmit_line_clock_prev    = 1'b0;
			state_next.rclk_prev    = 1'b0;
			state_next.tx_data      = 1'b0;
			state_next.tx_valid     = 1'b0;
			state_next.rx_pos       = 1'b0;
			state_next.rx_neg       = 1'b0;
			state_next.ami_polarity = 1'b0;
			state_next.rdi          = 1'b0;
			state_next.g1           = `MFLC_ZERO_BYTE;
		end
	end

	// State register; no power-up initial value is given.
	always_ff @(posedge CLK) begin
		state_reg <= state_next;
	end

	// Decoded configuration fields.
	always_comb begin
		CFG.format_sel = mflc_pkg::mflc_format_t'(
			{c0[`MFLC_FORMAT_SELECT_HIGH_BIT],
			 c0[`MFLC_FORMAT_SELECT_LOW_BIT]});
		CFG.format_valid = (CFG.format_sel !=
			mflc_pkg::MFLC_FMT_RESERVED);
		CFG.drop_slot_select = mflc_pkg::mflc_slot_t'(
			c0[`MFLC_DROP_SLOT_MSB:`MFLC_DROP_SLOT_LSB]);
		CFG.rx_front_reset = (CFG.drop_slot_select ==
			mflc_pkg::MFLC_SLOT_IDLE);
		CFG.add_slot_select = mflc_pkg::mflc_slot_t'(
			c0[`MFLC_ADD_SLOT_MSB:`MFLC_ADD_SLOT_LSB]);
		CFG.ds3_mode = c0[`MFLC_DS3_MODE_BIT];
		CFG.transmit_clock_inversion = c1[`MFLC_TX_CLK_INV_BIT];
		CFG.receive_clock_inversion  = c1[`MFLC_RX_CLK_INV_BIT];
		CFG.ring_mode                = c1[`MFLC_RING_MODE_BIT];
		CFG.facility_loopback_enable = c1[`MFLC_FACILITY_LBK_BIT];
		CFG.line_loopback_enable     = c1[`MFLC_LINE_LBK_BIT];
	end

	// Outputs; the receive line clock follows its source directly so the
	// launch edges line up with the clock that the far end sees.
	assign UP_RDATA      = state_reg.rdata;
	assign TX_CORE_DATA  = state_reg.tx_data;
	assign TX_CORE_VALID = state_reg.tx_valid;
	assign RX_LINE_CLK   = rx_src_clk;
	assign RX_LINE_POS   = state_reg.rx_pos;
	assign RX_LINE_NEG   = state_reg.rx_neg;
	assign G1_OUT        = state_reg.g1;
	assign RDI_OUT       = state_reg.rdi;

endmodule // mflc_top

`default_nettype wire

//--- testbench/mflc_top_asserts.sv
// Checker for the mapper format and loopback control bank.
// Assumes it is bound to mflc_top and sees only that module's ports.
`default_nettype none

module mflc_top_asserts (
	// Clock, reset and register writes.
	input wire logic                  CLK,
	input wire logic                  SRST,
	input wire logic [7:0]            UP_ADDR,
	input wire logic [7:0]            UP_WDATA,
	input wire logic                  UP_WR,
	// Line clocks and transmit sampling.
	input wire logic                  TX_LINE_CLK,
	input wire logic                  RX_CORE_CLK,
	input wire logic                  RX_LINE_CLK,
	input wire logic                  TX_CORE_VALID,
	// G1, alarms and decoded configuration.
	input wire logic [7:0]            G1_INTERNAL,
	input wire logic [7:0]            G1_EXTERNAL,
	input wire logic                  G1_EXTERNAL_SEL,
	input wire mflc_pkg::mflc_alarm_t ALARM_IN,
	input wire logic [7:0]            G1_OUT,
	input wire logic                  RDI_OUT,
	input wire mflc_pkg::mflc_cfg_t   CFG
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	// Companion alarm terms that must raise RDI.
	logic rdi_terms;
	assign rdi_terms = (ALARM_IN.format_select_high &
		(ALARM_IN.pointer_loss_alarm | ALARM_IN.path_ais_alarm)) |
		ALARM_IN.j1_loss_alarm |
		(ALARM_IN.e1_byte_ais_alarm & ~ALARM_IN.alarm_source_select) |
		(ALARM_IN.alarm_source_select &
		(ALARM_IN.external_status_input | ALARM_IN.path_ais_lead)) |
		(ALARM_IN.label_alarm_enable &
		(ALARM_IN.signal_label_mismatch | ALARM_IN.unequipped_label_detect));

	// A write to the first register, and the active transmit clock edge.
	sequence s_c0_write;
		UP_WR && UP_ADDR == 8'hc0;
	endsequence
	sequence s_tx_edge;
		!CFG.line_loopback_enable && (CFG.transmit_clock_inversion ?
			$fell(TX_LINE_CLK) : $rose(TX_LINE_CLK));
	endsequence

	a_format_write: assert property (s_c0_write |=>
		CFG.format_sel == $past(UP_WDATA[7:6]) &&
		CFG.drop_slot_select == $past(UP_WDATA[5:4]))
		else $error("format or drop field not loaded");
	a_format_valid: assert property (CFG.format_valid ==
		(CFG.format_sel != mflc_pkg::MFLC_FMT_RESERVED))
		else $error("format valid flag wrong");
	a_drop_idle: assert property (CFG.rx_front_reset ==
		(CFG.drop_slot_select == mflc_pkg::MFLC_SLOT_IDLE))
		else $error("receive front end reset wrong");
	a_reset_keeps: assert property ($fell(SRST) && !$past(UP_WR) |->
		CFG == $past(CFG)) else $error("reset changed configuration");
	a_facility_clock: assert property (CFG.facility_loopback_enable |->
		RX_LINE_CLK == TX_LINE_CLK) else $error("facility clock not looped");
	a_rx_clock_kept: assert property (!CFG.facility_loopback_enable |->
		RX_LINE_CLK == RX_CORE_CLK) else $error("receive clock not driven");
	a_tx_sample_edge: assert property (s_tx_edge |=> TX_CORE_VALID)
		else $error("transmit bit not sampled on its edge");
	a_g1_external: assert property (G1_EXTERNAL_SEL |=>
		G1_OUT == $past(G1_EXTERNAL)) else $error("external G1 not used");
	a_g1_ring: assert property (CFG.ring_mode && !G1_EXTERNAL_SEL |=>
		G1_OUT[7:4] == $past(ALARM_IN.febe_count) &&
		G1_OUT[2:0] == $past(G1_INTERNAL[2:0]))
		else $error("ring G1 fields wrong");
	a_rdi_terms: assert property (1'b1 |=> RDI_OUT == $past(rdi_terms))
		else $error("RDI does not follow alarm terms");
endmodule // mflc_top_asserts

`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the mapper format and loopback control bank.
// Assumes the design package, top module and checker are compiled first.
`default_nettype none

bind mflc_top mflc_top_asserts u_chk (.CLK(CLK), .SRST(SRST),
	.UP_ADDR(UP_ADDR), .UP_WDATA(UP_WDATA), .UP_WR(UP_WR),
	.TX_LINE_CLK(TX_LINE_CLK), .RX_CORE_CLK(RX_CORE_CLK),
	.RX_LINE_CLK(RX_LINE_CLK), .TX_CORE_VALID(TX_CORE_VALID),
	.G1_INTERNAL(G1_INTERNAL), .G1_EXTERNAL(G1_EXTERNAL),
	.G1_EXTERNAL_SEL(G1_EXTERNAL_SEL), .ALARM_IN(ALARM_IN),
	.G1_OUT(G1_OUT), .RDI_OUT(RDI_OUT), .CFG(CFG));

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus starts quiet, with reset held.
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, g1_sel = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, g1_int = 8'ha5, g1_ext = 8'h3c;
	logic transmit_line_clock = 1'b0, tpos = 1'b0, tneg = 1'b0, rclk = 1'b0, rdat = 1'b0;
	logic [7:0] rdata, g1_out;
	logic tdata, tvalid, rlclk, rpos, rneg, rdi;
	mflc_pkg::mflc_alarm_t alarm = '0;
	mflc_pkg::mflc_cfg_t cfg;
	int fails = 0, comparisons = 0, cycles = 0;

	mflc_top dut (.CLK(clk), .SRST(srst), .UP_ADDR(addr), .UP_WDATA(wdata),
		.UP_WR(wr), .UP_RD(rd), .UP_RDATA(rdata), .TX_LINE_CLK(transmit_line_clock),
		.TX_LINE_POS(tpos), .TX_LINE_NEG(tneg), .TX_CORE_DATA(tdata),
		.TX_CORE_VALID(tvalid), .RX_CORE_CLK(rclk), .RX_CORE_DATA(rdat),
		.RX_LINE_CLK(rlclk), .RX_LINE_POS(rpos), .RX_LINE_NEG(rneg),
		.G1_INTERNAL(g1_int), .G1_EXTERNAL(g1_ext), .G1_EXTERNAL_SEL(g1_sel),
		.ALARM_IN(alarm), .G1_OUT(g1_out), .RDI_OUT(rdi), .CFG(cfg));

	// A 50 ns clock.
	initial begin
		forever #25 clk = ~clk;
	end
	// The tests need under a thousand cycles, so a hang is cut off early.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			close_out;
		end
	end

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk);
	endtask
	// Strobes last one cycle; results are read at the falling edge.
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("read", exp, rdata);
	endtask

	// Every code of the format, drop and add fields, test bit kept clear.
	task automatic t_fields;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr_reg(8'hc0, {c, c, c, 1'b0, c[0]});
			chk("format", 8'(c), 8'(cfg.format_sel));
			chk("format ok", 8'(c != 2'h2), 8'(cfg.format_valid));
			chk("drop", 8'(c), 8'(cfg.drop_slot_select));
			chk("rx reset", 8'(c == 2'h3), 8'(cfg.rx_front_reset));
			chk("add", 8'(c), 8'(cfg.add_slot_select));
			chk("ds3", 8'(c[0]), 8'(cfg.ds3_mode));
		end
	endtask
	// A mid-run reset must leave both registers; an unmapped read gives 0.
	task automatic t_keep;
		wr_reg(8'hc0, 8'h6d);
		wr_reg(8'hc1, 8'ha9);
		@(posedge clk);
		srst <= 1'b1;
		step(3);
		srst <= 1'b0;
		rd_reg(8'hc0, 8'h6d);
		rd_reg(8'hc1, 8'ha9);
		rd_reg(8'h55, 8'h00);
	endtask
	// Both clock edges under each rail and inversion setting.
	task automatic t_tx;
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'hc1, {i[1], 1'b0, i[0], 5'h00});
			for (int l = 1; l >= 0; l--) begin
				@(posedge clk);
				transmit_line_clock <= l[0];
				tneg <= 1'b1;
				step(1);
				@(negedge clk);
				chk("tx valid", 8'(l[0] != i[0]), 8'(tvalid));
				if (l[0] != i[0])
					chk("tx data", 8'(i[1]), 8'(tdata));
			end
		end
	endtask
	// Line loopback samples the receive side; facility loops the clock.
	task automatic t_loops;
		wr_reg(8'hc1, 8'h02);
		@(posedge clk);
		rclk <= 1'b1;
		rdat <= 1'b1;
		step(1);
		@(negedge clk);
		chk("loop valid", 8'h01, 8'(tvalid));
		chk("loop data", 8'h01, 8'(tdata));
		@(posedge clk);
		rclk <= 1'b0;
		wr_reg(8'hc1, 8'h04);
		@(posedge clk);
		transmit_line_clock <= 1'b1;
		#1 chk("fac clk", 8'h01, 8'(rlclk));
		step(1);
		transmit_line_clock <= 1'b0;
	endtask
	// Data is 1 only at the launching edge, so a wrong edge shows as 0.
	task automatic t_rx;
		logic p, n;
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'hc1, {1'b0, i[1], 1'b0, i[0], 4'h0});
			for (int s = 1; s < 5; s++) begin
				@(posedge clk);
				rclk <= s[0];
				rdat <= (s[0] == i[0]);
				step(1);
				@(negedge clk);
				if (s[0] == i[0] && !i[1]) begin
					chk("rx nrz", 8'h02, {6'h00, rpos, rneg});
				end else if (s[0] == i[0] && s < 3) begin
					p = rpos;
					n = rneg;
					chk("rx mark", 8'h01, 8'(p ^ n));
				end else if (s[0] == i[0]) begin
					chk("rx alt", {6'h00, n, p}, {6'h00, rpos, rneg});
				end
			end
		end
	endtask
	// RDI terms one by one in ring mode, then the external and plain G1.
	task automatic t_g1;
		logic [10:0] al [9] = '{11'h480, 11'h080, 11'h020, 11'h010, 11'h210,
			11'h208, 11'h008, 11'h102, 11'h101};
		logic [8:0] re = 9'h1ad;
		wr_reg(8'hc1, 8'h08);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			if (i < 9)
				alarm <= mflc_pkg::mflc_alarm_t'({al[i], 4'h9});
			g1_sel <= (i == 9);
			step(2);
			@(negedge clk);
			if (i < 9)
				chk("ring g1", {4'h9, re[i], 3'h5}, g1_out);
			else
				chk("ext g1", 8'h3c, g1_out);
		end
		wr_reg(8'hc1, 8'h00);
		@(posedge clk);
		g1_sel <= 1'b0;
		step(2);
		@(negedge clk);
		chk("plain g1", 8'ha5, g1_out);
	endtask

	task automatic close_out;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Both registers are cleared while reset is held for 12 cycles.
	initial begin
		wr_reg(8'hc0, 8'h00);
		wr_reg(8'hc1, 8'h00);
		step(8);
		srst <= 1'b0;
		t_fields;
		$display("test fields done");
		t_keep;
		$display("test keep done");
		t_tx;
		$display("test tx done");
		t_loops;
		$display("test loops done");
		t_rx;
		$display("test rx done");
		t_g1;
		$display("test g1 done");
		close_out;
	end
endmodule // tb

`default_nettype wire
